// *** rsps_pkg.sv ***
// Package for the ramp-and-soak program sequencer: register map, field layout,
// reset values, timing counts, shared types.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
//
// Notes on behaviour
// R1: Each program holds up to 4 segments, each a target setpoint and a time.
// R2: Five programs chain through per-program links into profiles of up to 20 segments.
// R3: While running, the active setpoint comes from the program, not the fixed setpoint.
// R4: A segment time of zero ends the program after the preceding segment.
// R5: Nonzero tolerance freezes segment timing while process deviation exceeds it.
// R6: Zero tolerance lets segment time advance regardless of deviation.
// R7: Segment time is capped at 5999 seconds or minutes per time base.
// R8: Power return applies restart program, restart segment, resume point, or off.
// R9: Resume-at-point saves elapsed time only at one-minute granularity.
// R10: Resume-at-point with zero tolerance resumes at once, ignoring process value.
// R11: Resume-at-point with nonzero tolerance waits for process value within band.
// R12: A finished linked program starts its linked program with no delay.
// R13: Self links or closed chains repeat forever without operator action.
// R14: Event alarms assert in selected segments, only for alarms set to event type.
// R15: A one-second key press holds the program; another one-second press resumes.
// R16: The key holds or resumes only when the hold-key enable is set.
// R17: While held, the run indicator flashes instead of staying steady.
// R18: Ramps move setpoint linearly from previous to target; soaks stay constant.
// R19: While held, segment timing and generated setpoint stay frozen.
package rsps_pkg;

    // ******************************************************
    // Sizes
    // ******************************************************
    localparam int NUM_PROG = 5;
    localparam int NUM_SEG  = 4;
    localparam int NUM_ALM  = 2;

    // ******************************************************
    // Timing
    // ******************************************************
    localparam int  CLK_HZ         = 50_000_000;
    localparam int  SEC_NS         = 1_000_000_000;
    localparam int  CLK_NS         = SEC_NS / CLK_HZ;
    localparam int  TICK_CYCLES    = SEC_NS / CLK_NS;   // One second of pclk
    localparam int  KEY_HOLD_S     = 1;
    localparam int  SAVE_GRAN_S    = 60;
    localparam int  SEC_PER_MIN    = 60;
    localparam logic [15:0] SEG_TIME_MAX = 16'd5999;
    localparam int  FLASH_HALF_S   = 1;

    // ******************************************************
    // Register byte offsets
    // ******************************************************
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] CFG_OFS    = 12'h004;
    localparam logic [11:0] FIXSP_OFS  = 12'h008;
    localparam logic [11:0] PV_OFS     = 12'h00c;
    localparam logic [11:0] STAT_OFS   = 12'h010;
    localparam logic [11:0] ACTSP_OFS  = 12'h014;
    localparam logic [11:0] ISTAT_OFS  = 12'h018;
    localparam logic [11:0] IMASK_OFS  = 12'h01c;
    localparam logic [11:0] SAVE_OFS   = 12'h020;
    localparam logic [11:0] LINK_OFS   = 12'h040; // + 4 * program
    localparam logic [11:0] SEG_OFS    = 12'h100; // + 4 * (program*4+segment)

    // CTRL fields
    localparam int CTRL_RUN_BIT   = 0;  // Write 1 starts, 0 stops when CTRL_PWRUP_BIT is also 0
    localparam int CTRL_PWRUP_BIT = 1;  // Write 1 to apply power return policy
    localparam int CTRL_PROG_LSB  = 4;  // Start program, 3 bits
    // CFG fields
    localparam int CFG_TOL_LSB    = 0;  // program_tolerance, 16 bits
    localparam int CFG_POL_LSB    = 16; // resume_point_policy, 2 bits
    localparam int CFG_MIN_BIT    = 18; // Time base minutes
    localparam int CFG_HOLD_BIT   = 19; // hold_key_enable
    localparam int CFG_AEVT_LSB   = 20; // Alarm function is event, one per alarm
    // Segment word: [15:0] target, [28:16] time
    localparam int SEG_TIME_LSB   = 16;
    // Link word: [2:0] link target, [3] link enable, [7:4] segment_event_select a1, [11:8] a2
    localparam int LINK_EN_BIT    = 3;
    localparam int LINK_EV_LSB    = 4;

    // Interrupt status bits
    localparam int IRQ_SEG_END  = 0;
    localparam int IRQ_PROG_END = 1;
    localparam int IRQ_HOLD     = 2;
    localparam int IRQ_DONE     = 3;
    localparam int IRQ_W        = 4;

    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        RSPS_POL_PROG,
        RSPS_POL_SEG,
        RSPS_POL_POINT,
        RSPS_POL_OFF
    } rsps_pol_e;

    typedef enum logic [1:0] {
        RSPS_IDLE,
        RSPS_RUN,
        RSPS_HOLD,
        RSPS_WAIT_PV
    } rsps_state_e;

    typedef struct packed {
        logic [2:0]  prog;
        logic [1:0]  seg;
        logic [15:0] elapsed;
    } rsps_pos_s;

endpackage : rsps_pkg

// *** rsps_seq.sv ***
// Ramp-and-soak sequencer with APB register access.
// Assumes pclk at 50 MHz, key and process value synchronous to pclk.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module rsps_seq
    import rsps_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [15:0]        process_value,
    input  wire logic               hold_key,
    output logic      [15:0]        active_setpoint,
    output logic      [NUM_ALM-1:0] event_alarm,
    output logic                    run_indicator,
    output logic                    irq
);

    // ******************************************************
    // Storage and registers
    // ******************************************************
    logic [31:0]   seg_reg [NUM_PROG*NUM_SEG];
    logic [11:0]   link_reg [NUM_PROG];
    logic [31:0]   cfg_reg;
    logic [15:0]   fixsp_reg;
    logic [IRQ_W-1:0] istat_reg;
    logic [IRQ_W-1:0] imask_reg;
    rsps_state_e   state_reg;
    rsps_pos_s     pos_reg;
    rsps_pos_s     save_reg;
    logic [15:0]   start_sp_reg;
    logic [15:0]   sp_reg;
    logic [31:0]   tick_cnt_reg;
    logic [5:0]    min_cnt_reg;
    logic [31:0]   key_cnt_reg;
    logic          key_done_reg;
    logic          flash_reg;
    logic          saved_valid_reg;

    wire logic       wr_en = psel & penable & pwrite;
    wire logic       rd_en = psel & penable & ~pwrite;
    wire logic [15:0] tol  = cfg_reg[CFG_TOL_LSB +: 16];
    wire rsps_pol_e   pol  = rsps_pol_e'(cfg_reg[CFG_POL_LSB +: 2]);
    wire logic       sec_tick = (tick_cnt_reg == TICK - 1);

    // Flat segment index
    function automatic logic [4:0] seg_idx(input logic [2:0] p, input logic [1:0] s);
        seg_idx = 5'(p * NUM_SEG + s);
    endfunction : seg_idx

    // Absolute difference
    function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction : absdiff

    wire logic [31:0] cur_seg   = seg_reg[seg_idx(pos_reg.prog, pos_reg.seg)];
    wire logic [15:0] cur_tgt   = cur_seg[15:0];
    logic      [15:0] cur_time;
    wire logic [11:0] cur_link  = link_reg[pos_reg.prog];
    wire logic       in_band    = (tol == 16'h0000) || (absdiff(process_value, sp_reg) <= tol);

    // Clamp of segment time
    always_comb begin
        cur_time = cur_seg[SEG_TIME_LSB +: 16];
        if (cur_time > SEG_TIME_MAX) begin
            cur_time = SEG_TIME_MAX; // R7
        end
    end

    // ******************************************************
    // Time base, one-second enable
    // ******************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else if (sec_tick) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
        end
    end

    // Minute prescaler for minute time base
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_cnt_reg <= 6'h00;
        end else if (sec_tick) begin
            min_cnt_reg <= (min_cnt_reg == 6'(SEC_PER_MIN - 1)) ? 6'h00 : min_cnt_reg + 6'h01;
        end
    end

    wire logic unit_tick = sec_tick & (!cfg_reg[CFG_MIN_BIT] || min_cnt_reg == 6'(SEC_PER_MIN - 1));

    // ******************************************************
    // Key press detection
    // ******************************************************
    // One action per press, so a long press does not toggle repeatedly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_cnt_reg  <= 32'h0000_0000;
            key_done_reg <= 1'b0;
        end else if (!hold_key) begin
            key_cnt_reg  <= 32'h0000_0000;
            key_done_reg <= 1'b0;
        end else if (key_cnt_reg == 32'(KEY_HOLD_S * TICK - 1)) begin
            key_done_reg <= 1'b1;
            key_cnt_reg  <= 32'h0000_0000;
        end else if (!key_done_reg) begin
            key_cnt_reg <= key_cnt_reg + 32'h0000_0001;
        end
    end

    wire logic key_act = hold_key && !key_done_reg && key_cnt_reg == 32'(KEY_HOLD_S * TICK - 1)
                         && cfg_reg[CFG_HOLD_BIT]; // R15 R16

    // ******************************************************
    // Sequencer
    // ******************************************************
    wire logic ctrl_wr  = wr_en && paddr == CTRL_OFS;
    wire logic start    = ctrl_wr && pwdata[CTRL_RUN_BIT] && state_reg == RSPS_IDLE;
    wire logic stop     = ctrl_wr && !pwdata[CTRL_RUN_BIT] && !pwdata[CTRL_PWRUP_BIT];
    wire logic pwrup    = ctrl_wr && pwdata[CTRL_PWRUP_BIT] && saved_valid_reg;
    wire logic seg_end  = state_reg == RSPS_RUN && pos_reg.elapsed >= cur_time;
    logic      ev_seg_end;
    logic      ev_prog_end;
    logic      ev_done;

    // Next position after segment end
    logic [2:0] nxt_prog;
    logic [1:0] nxt_seg;
    logic       nxt_stop;
    logic [15:0] nxt_time;
    always_comb begin
        nxt_prog = pos_reg.prog;
        nxt_seg  = pos_reg.seg + 2'd1;
        nxt_stop = 1'b0;
        nxt_time = seg_reg[seg_idx(pos_reg.prog, nxt_seg)][SEG_TIME_LSB +: 16];
        if (pos_reg.seg == 2'(NUM_SEG - 1) || nxt_time == 16'h0000) begin // R4
            if (cur_link[LINK_EN_BIT]) begin
                nxt_prog = cur_link[2:0]; // R2 R12 R13
                nxt_seg  = 2'd0;
            end else begin
                nxt_stop = 1'b1;
            end
        end
    end

    // Program state machine and position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= RSPS_IDLE;
            pos_reg      <= '0;
            start_sp_reg <= 16'h0000;
            ev_seg_end   <= 1'b0;
            ev_prog_end  <= 1'b0;
            ev_done      <= 1'b0;
        end else begin
            ev_seg_end  <= 1'b0;
            ev_prog_end <= 1'b0;
            ev_done     <= 1'b0;
            if (stop) begin
                state_reg <= RSPS_IDLE;
            end else begin
                case (state_reg)
                    RSPS_IDLE: begin
                        if (start) begin
                            state_reg    <= RSPS_RUN;
                            pos_reg      <= '{prog: pwdata[CTRL_PROG_LSB +: 3], seg: 2'd0, elapsed: 16'h0000};
                            start_sp_reg <= sp_reg;
                        end else if (pwrup) begin // R8
                            start_sp_reg <= sp_reg;
                            case (pol)
                                RSPS_POL_PROG: begin
                                    state_reg <= RSPS_RUN;
                                    pos_reg   <= '{prog: save_reg.prog, seg: 2'd0, elapsed: 16'h0000};
                                end
                                RSPS_POL_SEG: begin
                                    state_reg <= RSPS_RUN;
                                    pos_reg   <= '{prog: save_reg.prog, seg: save_reg.seg, elapsed: 16'h0000};
                                end
                                RSPS_POL_POINT: begin
                                    pos_reg   <= save_reg; // R9
                                    state_reg <= RSPS_WAIT_PV;
                                end
                                default: state_reg <= RSPS_IDLE; // Control off, run flag clear
                            endcase
                        end
                    end
                    RSPS_WAIT_PV: begin
                        if (in_band) begin // R10 R11
                            state_reg <= RSPS_RUN;
                        end
                    end
                    RSPS_RUN: begin
                        if (key_act) begin
                            state_reg <= RSPS_HOLD; // R15
                        end else if (seg_end) begin
                            ev_seg_end   <= 1'b1;
                            start_sp_reg <= cur_tgt;
                            if (nxt_stop) begin
                                state_reg <= RSPS_IDLE;
                                ev_done   <= 1'b1;
                            end else begin
                                ev_prog_end <= nxt_prog != pos_reg.prog || nxt_seg == 2'd0;
                                pos_reg     <= '{prog: nxt_prog, seg: nxt_seg, elapsed: 16'h0000};
                            end
                        end else if (unit_tick && in_band) begin // R5 R6
                            pos_reg.elapsed <= pos_reg.elapsed + 16'h0001;
                        end
                    end
                    RSPS_HOLD: begin
                        if (key_act) begin
                            state_reg <= RSPS_RUN; // R19
                        end
                    end
                    default: state_reg <= RSPS_IDLE;
                endcase
            end
        end
    end

    // ******************************************************
    // Setpoint generation
    // ******************************************************
    // Linear interpolation; held and wait states leave it frozen, idle loads the fixed setpoint
    logic [15:0] ramp_sp;
    always_comb begin
        logic signed [47:0] span;
        span    = 48'(signed'({1'b0, cur_tgt})) - 48'(signed'({1'b0, start_sp_reg}));
        ramp_sp = cur_tgt;
        if (cur_time != 16'h0000 && pos_reg.elapsed < cur_time) begin
            ramp_sp = 16'(48'(signed'({1'b0, start_sp_reg}))
                      + (span * 48'(signed'({1'b0, pos_reg.elapsed}))) / 48'(signed'({1'b0, cur_time}))); // R18
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_reg <= 16'h0000;
        end else if (state_reg == RSPS_RUN) begin
            sp_reg <= ramp_sp; // R3 R18
        end else if (state_reg == RSPS_IDLE) begin
            sp_reg <= fixsp_reg;
        end
    end

    assign active_setpoint = sp_reg;

    // ******************************************************
    // Power-fail position save, one-minute granularity
    // ******************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            save_reg        <= '0;
            saved_valid_reg <= 1'b0;
        end else if (state_reg == RSPS_RUN) begin
            saved_valid_reg <= 1'b1;
            if (save_reg.prog != pos_reg.prog || save_reg.seg != pos_reg.seg) begin
                save_reg <= '{prog: pos_reg.prog, seg: pos_reg.seg, elapsed: 16'h0000};
            end else if (cfg_reg[CFG_MIN_BIT] || pos_reg.elapsed % 16'(SAVE_GRAN_S) == 16'h0000) begin
                save_reg.elapsed <= pos_reg.elapsed; // R9
            end
        end else if (ev_done || stop) begin
            saved_valid_reg <= 1'b0;
        end
    end

    // ******************************************************
    // Event alarms and run indicator
    // ******************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_alarm <= '0;
        end else begin
            for (int a = 0; a < NUM_ALM; a++) begin
                event_alarm[a] <= (state_reg == RSPS_RUN || state_reg == RSPS_HOLD)
                                  && cfg_reg[CFG_AEVT_LSB + a]
                                  && cur_link[LINK_EV_LSB + 4 * a + int'(pos_reg.seg)]; // R14
            end
        end
    end

    // Flash at one second per half period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_reg <= 1'b0;
        end else if (sec_tick) begin
            flash_reg <= ~flash_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_indicator <= 1'b0;
        end else begin
            run_indicator <= (state_reg == RSPS_RUN || state_reg == RSPS_WAIT_PV)
                             || (state_reg == RSPS_HOLD && flash_reg); // R17
        end
    end

    // ******************************************************
    // APB register writes
    // ******************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg   <= CFG_RESET;
            fixsp_reg <= 16'h0000;
            imask_reg <= '0;
            for (int i = 0; i < NUM_PROG; i++) begin
                link_reg[i] <= 12'h000;
            end
            for (int i = 0; i < NUM_PROG * NUM_SEG; i++) begin
                seg_reg[i] <= 32'h0000_0000;
            end
        end else if (wr_en) begin
            if (paddr == CFG_OFS) begin
                cfg_reg <= pwdata;
            end
            if (paddr == FIXSP_OFS) begin
                fixsp_reg <= pwdata[15:0];
            end
            if (paddr == IMASK_OFS) begin
                imask_reg <= pwdata[IRQ_W-1:0];
            end
            for (int i = 0; i < NUM_PROG; i++) begin
                if (paddr == LINK_OFS + 12'(4 * i)) begin
                    link_reg[i] <= pwdata[11:0];
                end
            end
            for (int i = 0; i < NUM_PROG * NUM_SEG; i++) begin
                if (paddr == SEG_OFS + 12'(4 * i)) begin
                    seg_reg[i] <= {3'b000, pwdata[28:16] > SEG_TIME_MAX[12:0] ? SEG_TIME_MAX[12:0] : pwdata[28:16],
                                   pwdata[15:0]}; // R1 R7
                end
            end
        end
    end

    // Sticky interrupt status; a read clears, a same-cycle event wins
    wire logic [IRQ_W-1:0] irq_ev = {ev_done, key_act && state_reg != RSPS_IDLE, ev_prog_end, ev_seg_end};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_reg <= '0;
        end else begin
            istat_reg <= ((rd_en && paddr == ISTAT_OFS) ? '0 : istat_reg) | irq_ev;
        end
    end

    assign irq = |(istat_reg & imask_reg);

    // ******************************************************
    // APB read mux
    // ******************************************************
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            CTRL_OFS:  rd_mux = {25'h0, pos_reg.prog, 3'h0, state_reg != RSPS_IDLE};
            CFG_OFS:   rd_mux = cfg_reg;
            FIXSP_OFS: rd_mux = {16'h0000, fixsp_reg};
            PV_OFS:    rd_mux = {16'h0000, process_value};
            STAT_OFS:  rd_mux = {9'h000, pos_reg.prog, pos_reg.seg, state_reg, pos_reg.elapsed};
            ACTSP_OFS: rd_mux = {16'h0000, sp_reg};
            ISTAT_OFS: rd_mux = {28'h0, istat_reg};
            IMASK_OFS: rd_mux = {28'h0, imask_reg};
            SAVE_OFS:  rd_mux = {saved_valid_reg, 10'h0, save_reg};
            default: begin
                rd_hit = 1'b0;
                for (int i = 0; i < NUM_PROG; i++) begin
                    if (paddr == LINK_OFS + 12'(4 * i)) begin
                        rd_mux = {20'h0, link_reg[i]};
                        rd_hit = 1'b1;
                    end
                end
                for (int i = 0; i < NUM_PROG * NUM_SEG; i++) begin
                    if (paddr == SEG_OFS + 12'(4 * i)) begin
                        rd_mux = seg_reg[i];
                        rd_hit = 1'b1;
                    end
                end
            end
        endcase
    end

    // Read data registered in the setup cycle, so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~rd_hit;

endmodule : rsps_seq
`default_nettype wire

// *** rsps_seq_assertions.sv ***
// Checker for the sequencer's bus answers and setpoint readback.
// Sees only top-level ports; bound to rsps_seq at the foot.
`timescale 1ns/1ns
`default_nettype none
module rsps_seq_assertions
    import rsps_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] active_setpoint
);
    // Read setup cycle, and the hole between SAVE and the link table
    wire logic rd_set = psel && !penable && !pwrite;
    wire logic gap    = paddr inside {[12'h024:12'h03c]};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_high_a: assert property (pready) else $error("pready low");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    err_gap_a: assert property (psel && penable && gap |-> pslverr) else $error("no pslverr on hole");
    gap_zero_a: assert property (rd_set && gap |=> prdata == 32'h0) else $error("hole read not zero");
    rdata_hold_a: assert property (!rd_set |=> $stable(prdata)) else $error("prdata moved");
    sp_read_a: assert property (rd_set && paddr == ACTSP_OFS |=> prdata[15:0] == $past(active_setpoint))
        else $error("setpoint readback wrong");
    seg_clamp_a: assert property (rd_set && paddr >= SEG_OFS && paddr < 12'h150 |=> prdata[28:16] <= 13'd5999)
        else $error("segment time above cap");
    prog_range_a: assert property (rd_set && paddr == CTRL_OFS |=> prdata[6:4] < 3'd5)
        else $error("program number out of range");
endmodule : rsps_seq_assertions
bind rsps_seq rsps_seq_assertions u_chk (.*);
`default_nettype wire

// *** rsps_plant.sv ***
// Stand-in for the process and the operator key.
// Process value trails the setpoint one cycle plus a bench-chosen offset.
`timescale 1ns/1ns
`default_nettype none
module rsps_plant
    import rsps_pkg::*;
(
    input wire logic        pclk,
    input wire logic [15:0] setpoint,
    input wire logic [15:0] pv_offset,
    input wire logic        press,
    output var logic [15:0] process_value,
    output var logic        hold_key
);
    // Known levels from time zero, then a lagging follower
    initial begin
        process_value = 16'h0;
        hold_key = 1'b0;
    end
    always @(posedge pclk) begin
        process_value <= setpoint + pv_offset;
        hold_key <= press;
    end
endmodule : rsps_plant
`default_nettype wire

// *** rsps_seq_tb.sv ***
// Self-checking bench: APB master, plant model, ramp/soak expectations.
// Assumes one second shortened to TK cycles through the TICK parameter.
`timescale 1ns/1ns
`default_nettype none
module rsps_seq_tb
    import rsps_pkg::*;
;
    localparam int TK = 20;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, key = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, a;
    logic        pready, pslverr, e, hold_key, run_indicator, irq;
    logic [15:0] process_value, active_setpoint, off = 0;
    logic [1:0]  event_alarm;
    int          errors = 0, samples_checked = 0, seed = 32, cyc = 0, tog;
    always #10 pclk = ~pclk;
    rsps_seq #(.TICK(TK)) u_rsps_seq (.*);
    rsps_plant u_rsps_plant (.pclk, .setpoint(active_setpoint), .pv_offset(off), .press(key), .process_value, .hold_key);
    // ****
    // Bus, compare and key tasks
    // ****
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task st(input logic [1:0] s);
        apb(0, STAT_OFS, 0);
        chk(32'(r[17:16]), 32'(s));
    endtask : st
    // Held a little past one second so the press always counts
    task press();
        key <= 1'b1;
        repeat (TK + 4) @(posedge pclk);
        key <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : press
    task end_of_test();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // Hang guard, well above the few hundred cycles expected
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, CFG_OFS, 0);
        chk(r, CFG_RESET);
        apb(0, 12'h030, 0);
        chk({r[30:0], e}, 32'h1);
        apb(1, FIXSP_OFS, 32'd100);
        apb(1, IMASK_OFS, 32'h8);
        apb(1, SEG_OFS, 32'h0002_03e8);
        apb(1, SEG_OFS + 12'h4, 32'h0003_03e8);
        apb(1, SEG_OFS + 12'h8, 32'h0);
        apb(1, SEG_OFS + 12'hc, 32'h1fff_0000);
        apb(0, SEG_OFS + 12'hc, 0);
        chk(32'(r[28:16]), 32'd5999);
        apb(1, CTRL_OFS, 32'h1);
        repeat (TK * 7 / 2) @(posedge pclk);
        apb(0, ACTSP_OFS, 0);
        chk(32'(r[15:0]), 32'd1000);
        repeat (TK * 3) @(posedge pclk);
        st(2'd0);
        chk(32'(irq), 32'h1);
        apb(0, ISTAT_OFS, 0);
        chk(32'(r[IRQ_DONE]), 32'h1);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        // Large random deviation must stall the segment clock
        apb(1, CFG_OFS, 32'd5);
        off <= 16'h0100 | (16'($random(seed)) & 16'h0fff);
        apb(1, CTRL_OFS, 32'h1);
        repeat (TK * 3) @(posedge pclk);
        apb(0, STAT_OFS, 0);
        chk(32'(r[17:0]), 32'h1_0000);
        off <= 16'h0;
        repeat (TK * 7) @(posedge pclk);
        st(2'd0);
        apb(1, CFG_OFS, 32'h0);
        apb(1, CTRL_OFS, 32'h1);
        press();
        st(2'd1);
        apb(1, CFG_OFS, 32'h0008_0000);
        press();
        st(2'd2);
        apb(0, ACTSP_OFS, 0);
        a = r;
        tog = 0;
        repeat (TK * 3) begin
            @(posedge pclk);
            tog += int'(run_indicator);
        end
        chk(32'(tog >= TK && tog <= 2 * TK), 32'h1);
        apb(0, ACTSP_OFS, 0);
        chk(r, a);
        press();
        st(2'd1);
        // Self-linked loop with event alarm, then power return
        apb(1, CFG_OFS, 32'h0010_0000);
        apb(1, LINK_OFS, 32'hf8);
        repeat (TK * 7) @(posedge pclk);
        chk(32'(event_alarm), 32'h1);
        st(2'd1);
        apb(1, CTRL_OFS, 32'h0);
        apb(1, CFG_OFS, 32'h0002_0005);
        off <= 16'h0100;
        apb(1, CTRL_OFS, 32'h2);
        st(2'd3);
        off <= 16'h0;
        repeat (3) @(posedge pclk);
        st(2'd1);
        end_of_test();
    end
endmodule : rsps_seq_tb
`default_nettype wire
